// [src/psc_defines.vh]
// Constants for the processor sideband control block
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// ----------------------------------------------------------------
// Machine check configuration field positions
// ----------------------------------------------------------------
`define PSC_MC_EN_BIT 0
`define PSC_MC_INTERNAL_ERROR_N_BIT 1
`define PSC_MC_INIT_BIT 2
`define PSC_MC_ANY_BIT 3
`define PSC_MC_CFG_W 4

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PSC_LIC_EN_RST 1'h1
`define PSC_SYNC_RST 1'h0
`define PSC_TCC_HOLD_NS 40
`define PSC_CLK_PERIOD_NS 4
`define PSC_TCC_HOLD_CYC ((`PSC_TCC_HOLD_NS + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
`define PSC_TCC_CNT_W 4

`endif

// [src/psc_sync2.v]
// Two-stage synchronizer for an asynchronous level
`timescale 1ns/1ps
module psc_sync2 (
    input wire clk_in,
    input wire srst_in,
    input wire async_in,
    output wire sync_out
);
    reg meta_q;
    reg sync_q;

    // ----------------------------------------------------------------
    // Synchronizer stages
    // ----------------------------------------------------------------
    // First stage read only by second stage
    always @(posedge clk_in) begin
        if (srst_in) begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // psc_sync2

// [src/psc_top.v]
// Sideband control logic: numeric error, soft init, local irqs, lock, errors, thermal
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_top (
    input wire CLK_IN,
    input wire SRST_IN,
    // Asynchronous pins; local irqs and temperature sense active high, the others active low
    input wire NUMERIC_ERROR_IGNORE_N_IN,
    input wire SOFT_INIT_N_IN,
    input wire [1:0] LOCAL_IRQ_IN,
    input wire OVER_TEMP_SENSE_IN,
    input wire MACHINE_CHECK_ERROR_N_IN,
    // Core-side, same clock
    input wire NATIVE_ERROR_REPORT_BIT_IN,
    input wire FP_ERROR_EVENT_IN,
    input wire FP_NONCONTROL_OP_IN,
    input wire LIC_DISABLE_IN,
    input wire LIC_ENABLE_IN,
    input wire INTERNAL_ERROR_EVENT_IN,
    input wire BUS_ERROR_SEEN_IN,
    input wire BUS_INITIATOR_IN,
    input wire [`PSC_MC_CFG_W-1:0] MC_CFG_IN,
    input wire TCC_ENABLE_IN,
    input wire SNOOP_REQ_IN,
    input wire LOCKED_SEQ_START_IN,
    input wire LOCKED_SEQ_END_IN,
    // Outputs
    output reg FP_EXCEPTION_OUT,
    output reg INT_REG_RESET_OUT,
    output reg FETCH_RESET_VECTOR_OUT,
    output reg SNOOP_ACK_OUT,
    output reg MASKABLE_IRQ_OUT,
    output reg NONMASKABLE_IRQ_OUT,
    output reg [1:0] LOCAL_IRQ_OUT,
    output reg LIC_ENABLED_OUT,
    output reg ATOMIC_HOLD_N_OUT,
    output reg ATOMIC_HOLD_N_OE_N_OUT,
    output reg MACHINE_CHECK_ERROR_N_OUT,
    output reg MACHINE_CHECK_ERROR_N_OE_N_OUT,
    output reg MACHINE_CHECK_SEEN_OUT,
    output reg INTERNAL_ERROR_N_OUT,
    output reg OVER_TEMPERATURE_N_OUT,
    output reg TCC_ACTIVE_OUT
);
    // ----------------------------------------------------------------
    // Synchronized inputs
    // ----------------------------------------------------------------
    wire numeric_error_ignore_n_n_s;
    wire init_n_s;
    wire irq0_s;
    wire irq1_s;
    wire hot_s;
    wire machine_check_error_n_n_s;

    psc_sync2 u_sync_numeric_error_ignore_n (.clk_in(CLK_IN), .srst_in(SRST_IN),
        .async_in(NUMERIC_ERROR_IGNORE_N_IN), .sync_out(numeric_error_ignore_n_n_s));
    psc_sync2 u_sync_init (.clk_in(CLK_IN), .srst_in(SRST_IN),
        .async_in(SOFT_INIT_N_IN), .sync_out(init_n_s));
    psc_sync2 u_sync_irq0 (.clk_in(CLK_IN), .srst_in(SRST_IN),
        .async_in(LOCAL_IRQ_IN[0]), .sync_out(irq0_s));
    psc_sync2 u_sync_irq1 (.clk_in(CLK_IN), .srst_in(SRST_IN),
        .async_in(LOCAL_IRQ_IN[1]), .sync_out(irq1_s));
    psc_sync2 u_sync_hot (.clk_in(CLK_IN), .srst_in(SRST_IN),
        .async_in(OVER_TEMP_SENSE_IN), .sync_out(hot_s));
    psc_sync2 u_sync_machine_check_error_n (.clk_in(CLK_IN), .srst_in(SRST_IN),
        .async_in(MACHINE_CHECK_ERROR_N_IN), .sync_out(machine_check_error_n_n_s));

    // ----------------------------------------------------------------
    // Numeric error handling
    // ----------------------------------------------------------------
    reg fp_pend_q;
    reg init_prev_q;
    reg lic_en_q;
    reg lock_q;
    reg internal_error_n_q;
    reg [`PSC_TCC_CNT_W-1:0] tcc_cnt_q;

    // Hold count cut to the counter width on purpose
    localparam [31:0] TCC_HOLD_FULL = `PSC_TCC_HOLD_CYC;
    localparam [`PSC_TCC_CNT_W-1:0] TCC_HOLD = TCC_HOLD_FULL[`PSC_TCC_CNT_W-1:0];

    // Ignore input counts only when native reporting is off
    wire ignore_act = ~numeric_error_ignore_n_n_s & ~NATIVE_ERROR_REPORT_BIT_IN;
    wire init_act = ~init_n_s;

    // Pending float error and exception on next noncontrol op
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            fp_pend_q <= 1'h0;
            FP_EXCEPTION_OUT <= 1'h0;
        end else begin
            FP_EXCEPTION_OUT <= 1'h0;
            if (FP_ERROR_EVENT_IN) begin
                fp_pend_q <= 1'h1; // Set wins over clear
            end else if (FP_NONCONTROL_OP_IN && fp_pend_q && !ignore_act) begin
                FP_EXCEPTION_OUT <= 1'h1;
                fp_pend_q <= 1'h0;
            end
            // Ignore asserted: error stays pending, op proceeds
        end
    end

    // ----------------------------------------------------------------
    // Soft init and snoops
    // ----------------------------------------------------------------
    // Integer reset while held, vector fetch on release; float state untouched
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            init_prev_q <= 1'h0;
            INT_REG_RESET_OUT <= 1'h0;
            FETCH_RESET_VECTOR_OUT <= 1'h0;
            SNOOP_ACK_OUT <= 1'h0;
        end else begin
            init_prev_q <= init_act;
            INT_REG_RESET_OUT <= init_act;
            FETCH_RESET_VECTOR_OUT <= init_prev_q & ~init_act;
            SNOOP_ACK_OUT <= SNOOP_REQ_IN;
        end
    end

    // ----------------------------------------------------------------
    // Local interrupt inputs
    // ----------------------------------------------------------------
    // Controller enabled after reset; software may switch it
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            lic_en_q <= `PSC_LIC_EN_RST;
            LIC_ENABLED_OUT <= `PSC_LIC_EN_RST;
            MASKABLE_IRQ_OUT <= 1'h0;
            NONMASKABLE_IRQ_OUT <= 1'h0;
            LOCAL_IRQ_OUT <= 2'h0;
        end else begin
            if (LIC_DISABLE_IN) begin
                lic_en_q <= 1'h0;
            end else if (LIC_ENABLE_IN) begin
                lic_en_q <= 1'h1;
            end
            LIC_ENABLED_OUT <= lic_en_q;
            MASKABLE_IRQ_OUT <= ~lic_en_q & irq0_s;
            NONMASKABLE_IRQ_OUT <= ~lic_en_q & irq1_s;
            LOCAL_IRQ_OUT <= lic_en_q ? {irq1_s, irq0_s} : 2'h0;
        end
    end

    // ----------------------------------------------------------------
    // Atomic sequence hold, open drain
    // ----------------------------------------------------------------
    // Held from a start until the next end; priority agent waits on it
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            lock_q <= 1'h0;
            ATOMIC_HOLD_N_OUT <= 1'h0;
            ATOMIC_HOLD_N_OE_N_OUT <= 1'h1;
        end else begin
            if (LOCKED_SEQ_START_IN) begin
                lock_q <= 1'h1;
            end else if (LOCKED_SEQ_END_IN) begin
                lock_q <= 1'h0;
            end
            ATOMIC_HOLD_N_OUT <= 1'h0;
            ATOMIC_HOLD_N_OE_N_OUT <= ~(lock_q | LOCKED_SEQ_START_IN);
        end
    end

    // ----------------------------------------------------------------
    // Internal and machine check errors
    // ----------------------------------------------------------------
    wire mc_en = MC_CFG_IN[`PSC_MC_EN_BIT];
    wire mc_fire = mc_en & ((MC_CFG_IN[`PSC_MC_INTERNAL_ERROR_N_BIT] & INTERNAL_ERROR_EVENT_IN) |
        (MC_CFG_IN[`PSC_MC_INIT_BIT] & BUS_INITIATOR_IN & BUS_ERROR_SEEN_IN) |
        (MC_CFG_IN[`PSC_MC_ANY_BIT] & BUS_ERROR_SEEN_IN));

    // Internal error sticky to reset; machine check pulsed per event
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            internal_error_n_q <= 1'h0;
            INTERNAL_ERROR_N_OUT <= 1'h1;
            MACHINE_CHECK_ERROR_N_OUT <= 1'h0;
            MACHINE_CHECK_ERROR_N_OE_N_OUT <= 1'h1;
            MACHINE_CHECK_SEEN_OUT <= 1'h0;
        end else begin
            if (INTERNAL_ERROR_EVENT_IN) begin
                internal_error_n_q <= 1'h1;
            end
            INTERNAL_ERROR_N_OUT <= ~(internal_error_n_q | INTERNAL_ERROR_EVENT_IN);
            MACHINE_CHECK_ERROR_N_OUT <= 1'h0;
            MACHINE_CHECK_ERROR_N_OE_N_OUT <= ~mc_fire;
            MACHINE_CHECK_SEEN_OUT <= ~machine_check_error_n_n_s;
        end
    end

    // ----------------------------------------------------------------
    // Thermal monitoring
    // ----------------------------------------------------------------
    // Thermal control held a short time after over-temperature drops
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            OVER_TEMPERATURE_N_OUT <= 1'h1;
            TCC_ACTIVE_OUT <= 1'h0;
            tcc_cnt_q <= {`PSC_TCC_CNT_W{1'h0}};
        end else begin
            OVER_TEMPERATURE_N_OUT <= ~hot_s;
            if (hot_s && TCC_ENABLE_IN) begin
                TCC_ACTIVE_OUT <= 1'h1;
                tcc_cnt_q <= TCC_HOLD;
            end else if (tcc_cnt_q != {`PSC_TCC_CNT_W{1'h0}}) begin
                tcc_cnt_q <= tcc_cnt_q - 1'h1;
            end else begin
                TCC_ACTIVE_OUT <= 1'h0;
            end
        end
    end
endmodule // psc_top

// [test/psc_partner.sv]
// Model of the shared error wire pull-up and other host bus agents
`timescale 1ns/1ps
module psc_partner (
    input wire clk_in,
    input wire mce_n_in,
    input wire mce_oe_n_in,
    input wire hold_oe_n_in,
    input wire prio_req_in,
    output wire mce_wire_n_out,
    output reg prio_owner_out
);
    // Pulled-up shared error wire, low while driven
    assign mce_wire_n_out = mce_oe_n_in ? 1'h1 : mce_n_in;
    // Priority agent takes the bus only with the hold wire released
    always @(posedge clk_in) begin
        prio_owner_out <= prio_req_in & hold_oe_n_in;
    end
endmodule // psc_partner

// [test/psc_props.sv]
// Concurrent checks on the sideband control block ports
`timescale 1ns/1ps
module psc_props (
    input wire CLK_IN,
    input wire SRST_IN,
    input wire SNOOP_REQ_IN,
    input wire SNOOP_ACK_OUT,
    input wire FP_NONCONTROL_OP_IN,
    input wire FP_EXCEPTION_OUT,
    input wire INTERNAL_ERROR_EVENT_IN,
    input wire INTERNAL_ERROR_N_OUT,
    input wire LOCKED_SEQ_START_IN,
    input wire ATOMIC_HOLD_N_OE_N_OUT,
    input wire [3:0] MC_CFG_IN,
    input wire BUS_ERROR_SEEN_IN,
    input wire MACHINE_CHECK_ERROR_N_OE_N_OUT,
    input wire TCC_ENABLE_IN,
    input wire TCC_ACTIVE_OUT,
    input wire OVER_TEMPERATURE_N_OUT,
    input wire LIC_ENABLED_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    // Relations between causes and registered answers
    snoop_ack_a: assert property (SNOOP_REQ_IN |=> SNOOP_ACK_OUT) else $error("snoop ack missing");
    fp_cause_a: assert property (FP_EXCEPTION_OUT |-> $past(FP_NONCONTROL_OP_IN)) else $error("stray fp exc");
    internal_error_n_set_a: assert property (INTERNAL_ERROR_EVENT_IN |=> !INTERNAL_ERROR_N_OUT) else $error("internal_error_n late");
    internal_error_n_hold_a: assert property (!INTERNAL_ERROR_N_OUT |=> !INTERNAL_ERROR_N_OUT) else $error("internal_error_n dropped");
    lock_hold_a: assert property (LOCKED_SEQ_START_IN |=> !ATOMIC_HOLD_N_OE_N_OUT) else $error("hold late");
    mc_any_a: assert property (MC_CFG_IN[0] && MC_CFG_IN[3] && BUS_ERROR_SEEN_IN
        |=> !MACHINE_CHECK_ERROR_N_OE_N_OUT) else $error("mc not driven");
    mc_off_a: assert property (!MC_CFG_IN[0] |=> MACHINE_CHECK_ERROR_N_OE_N_OUT) else $error("mc while off");
    tcc_on_a: assert property ($fell(OVER_TEMPERATURE_N_OUT) && TCC_ENABLE_IN
        |-> ##[0:1] TCC_ACTIVE_OUT) else $error("tcc not engaged");
    tcc_hold_a: assert property ($rose(OVER_TEMPERATURE_N_OUT) && $past(TCC_ACTIVE_OUT)
        |-> TCC_ACTIVE_OUT [*8] ##[1:6] !TCC_ACTIVE_OUT) else $error("tcc hold wrong");
    lic_rst_a: assert property ($fell(SRST_IN) |-> LIC_ENABLED_OUT) else $error("lic off at reset");
    // Main scenarios reached
    snoop_c: cover property (SNOOP_REQ_IN);
    mc_c: cover property (!MACHINE_CHECK_ERROR_N_OE_N_OUT);
    tcc_c: cover property ($rose(OVER_TEMPERATURE_N_OUT) && TCC_ACTIVE_OUT);
endmodule // psc_props
bind psc_top psc_props u_props (.*);

// [test/psc_top_tb.sv]
// Self-checking bench for the sideband control block
`timescale 1ns/1ps
module psc_top_tb;
    reg CLK_IN, SRST_IN, NUMERIC_ERROR_IGNORE_N_IN, SOFT_INIT_N_IN, OVER_TEMP_SENSE_IN, NATIVE_ERROR_REPORT_BIT_IN;
    reg FP_ERROR_EVENT_IN, FP_NONCONTROL_OP_IN, LIC_DISABLE_IN, LIC_ENABLE_IN, INTERNAL_ERROR_EVENT_IN;
    reg BUS_ERROR_SEEN_IN, BUS_INITIATOR_IN, TCC_ENABLE_IN, SNOOP_REQ_IN, LOCKED_SEQ_START_IN, LOCKED_SEQ_END_IN;
    reg prio_req;
    reg [1:0] LOCAL_IRQ_IN;
    reg [3:0] MC_CFG_IN;
    wire MACHINE_CHECK_ERROR_N_IN, prio_owner, FP_EXCEPTION_OUT, INT_REG_RESET_OUT, FETCH_RESET_VECTOR_OUT;
    wire SNOOP_ACK_OUT, MASKABLE_IRQ_OUT, NONMASKABLE_IRQ_OUT, LIC_ENABLED_OUT, ATOMIC_HOLD_N_OUT;
    wire ATOMIC_HOLD_N_OE_N_OUT, MACHINE_CHECK_SEEN_OUT, MACHINE_CHECK_ERROR_N_OUT, MACHINE_CHECK_ERROR_N_OE_N_OUT;
    wire INTERNAL_ERROR_N_OUT, OVER_TEMPERATURE_N_OUT, TCC_ACTIVE_OUT;
    wire [1:0] LOCAL_IRQ_OUT;
    integer n_errors, tests_run, cycles, i, k;
    psc_top DUT (.*);
    psc_partner u_partner (.clk_in(CLK_IN), .mce_n_in(MACHINE_CHECK_ERROR_N_OUT),
        .mce_oe_n_in(MACHINE_CHECK_ERROR_N_OE_N_OUT), .hold_oe_n_in(ATOMIC_HOLD_N_OE_N_OUT),
        .prio_req_in(prio_req), .mce_wire_n_out(MACHINE_CHECK_ERROR_N_IN), .prio_owner_out(prio_owner));
    // Clock and hang guard
    initial begin
        CLK_IN = 1'h0;
        forever #2 CLK_IN = ~CLK_IN;
    end
    always @(posedge CLK_IN) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end
    // Shared tasks
    task cyc(input integer n);
        repeat (n) @(posedge CLK_IN);
        #1;
    endtask
    task chk(input actual, input expv);
        tests_run = tests_run + 1;
        if (actual !== expv) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %b expected %b", $time, actual, expv);
        end
    endtask
    task wrap_up;
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task fp_case(input ign_n, input ne, input expv);
        NUMERIC_ERROR_IGNORE_N_IN = ign_n; // Held stable through the case
        NATIVE_ERROR_REPORT_BIT_IN = ne;
        cyc(4);
        FP_ERROR_EVENT_IN = 1'h1;
        cyc(1);
        FP_ERROR_EVENT_IN = 1'h0;
        FP_NONCONTROL_OP_IN = 1'h1;
        cyc(1);
        FP_NONCONTROL_OP_IN = 1'h0;
        chk(FP_EXCEPTION_OUT, expv);
    endtask
    task mc_case(input [3:0] cfg, input init, input use_int, input expv);
        MC_CFG_IN = cfg;
        BUS_INITIATOR_IN = init;
        cyc(1);
        INTERNAL_ERROR_EVENT_IN = use_int;
        BUS_ERROR_SEEN_IN = !use_int;
        cyc(1);
        INTERNAL_ERROR_EVENT_IN = 1'h0;
        BUS_ERROR_SEEN_IN = 1'h0;
        chk(MACHINE_CHECK_ERROR_N_OE_N_OUT, expv);
        cyc(3);
        chk(MACHINE_CHECK_SEEN_OUT, !expv);
    endtask
    // Main sequence
    initial begin
        {n_errors, tests_run, cycles, FP_ERROR_EVENT_IN, FP_NONCONTROL_OP_IN, LIC_DISABLE_IN, LIC_ENABLE_IN} = 0;
        {INTERNAL_ERROR_EVENT_IN, BUS_ERROR_SEEN_IN, BUS_INITIATOR_IN, TCC_ENABLE_IN, SNOOP_REQ_IN, prio_req} = 0;
        {LOCKED_SEQ_START_IN, LOCKED_SEQ_END_IN, LOCAL_IRQ_IN, MC_CFG_IN, OVER_TEMP_SENSE_IN} = 0;
        {SRST_IN, NUMERIC_ERROR_IGNORE_N_IN, SOFT_INIT_N_IN, NATIVE_ERROR_REPORT_BIT_IN} = 4'hE;
        cyc(10);
        SRST_IN = 1'h0;
        cyc(6);
        chk(LIC_ENABLED_OUT, 1'h1);
        SOFT_INIT_N_IN = 1'h0;
        cyc(4);
        chk(INT_REG_RESET_OUT, 1'h1);
        SNOOP_REQ_IN = 1'h1;
        cyc(1);
        SNOOP_REQ_IN = 1'h0;
        chk(SNOOP_ACK_OUT, 1'h1);
        SOFT_INIT_N_IN = 1'h1;
        k = 0;
        for (i = 0; i < 6; i = i + 1) begin
            cyc(1);
            k = k + FETCH_RESET_VECTOR_OUT;
        end
        chk(k == 1, 1'h1);
        chk(INT_REG_RESET_OUT, 1'h0);
        fp_case(1'h1, 1'h0, 1'h1);
        fp_case(1'h0, 1'h0, 1'h0);
        fp_case(1'h0, 1'h1, 1'h1);
        LOCAL_IRQ_IN = 2'h3;
        cyc(4);
        chk(LOCAL_IRQ_OUT == 2'h3, 1'h1);
        LIC_DISABLE_IN = 1'h1;
        cyc(1);
        LIC_DISABLE_IN = 1'h0;
        LOCAL_IRQ_IN = 2'h2;
        cyc(4);
        chk(MASKABLE_IRQ_OUT, 1'h0);
        chk(NONMASKABLE_IRQ_OUT, 1'h1);
        LOCAL_IRQ_IN = 2'h1;
        cyc(4);
        chk(MASKABLE_IRQ_OUT, 1'h1);
        chk(NONMASKABLE_IRQ_OUT, 1'h0);
        LIC_ENABLE_IN = 1'h1;
        cyc(1);
        LIC_ENABLE_IN = 1'h0;
        cyc(1);
        chk(LIC_ENABLED_OUT, 1'h1);
        chk(LOCAL_IRQ_OUT == 2'h1, 1'h1);
        LOCKED_SEQ_START_IN = 1'h1;
        cyc(1);
        LOCKED_SEQ_START_IN = 1'h0;
        prio_req = 1'h1;
        cyc(3);
        chk(ATOMIC_HOLD_N_OE_N_OUT, 1'h0);
        chk(ATOMIC_HOLD_N_OUT, 1'h0);
        chk(prio_owner, 1'h0);
        LOCKED_SEQ_END_IN = 1'h1;
        cyc(1);
        LOCKED_SEQ_END_IN = 1'h0;
        cyc(2);
        chk(ATOMIC_HOLD_N_OE_N_OUT, 1'h1);
        chk(prio_owner, 1'h1);
        mc_case(4'h0, 1'h1, 1'h0, 1'h1);
        mc_case(4'h9, 1'h0, 1'h0, 1'h0);
        mc_case(4'h5, 1'h0, 1'h0, 1'h1);
        mc_case(4'h5, 1'h1, 1'h0, 1'h0);
        mc_case(4'h1, 1'h0, 1'h1, 1'h1);
        mc_case(4'h3, 1'h0, 1'h1, 1'h0);
        chk(MACHINE_CHECK_ERROR_N_OUT, 1'h0);
        TCC_ENABLE_IN = 1'h1;
        OVER_TEMP_SENSE_IN = 1'h1;
        cyc(4);
        chk(OVER_TEMPERATURE_N_OUT, 1'h0);
        chk(TCC_ACTIVE_OUT, 1'h1);
        OVER_TEMP_SENSE_IN = 1'h0;
        cyc(5);
        chk(OVER_TEMPERATURE_N_OUT, 1'h1);
        chk(TCC_ACTIVE_OUT, 1'h1);
        cyc(10);
        chk(TCC_ACTIVE_OUT, 1'h0);
        chk(INTERNAL_ERROR_N_OUT, 1'h0);
        SRST_IN = 1'h1;
        cyc(2);
        SRST_IN = 1'h0;
        cyc(1);
        chk(INTERNAL_ERROR_N_OUT, 1'h1);
        wrap_up;
    end
endmodule // psc_top_tb
